// file: src/camera_trigger_control.sv
// Camera trigger controller with AXI4-Lite registers
//
// Functional notes
// [RL1] Falling mode: one capture per high-to-low edge on the trigger input.
// [RL2] Rising mode: one capture per low-to-high edge on the trigger input.
// [RL3] Software mode ignores the pin and captures back to back continuously.
// [RL4] With delay enabled, wait the programmed delay before exposure starts.
// [RL5] No trigger within timeout in trigger mode: flag it, bump error count.
// [RL6] With status enabled, sample the trigger pin level for host reads.
// [RL7] Global start in trigger mode exposes all sensor rows at once.
// [RL8] Exposure, then transfer; no new exposure until transfer has finished.
// [RL9] Synchronise pin, one request per edge, restart timeout on each trigger.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module camera_trigger_control (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [4:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [4:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // External trigger pin
    input  wire logic        trigIn,
    // Sensor sequencing
    output logic             exposeStart,
    output logic             exposing,
    output logic             globalRows,
    output logic             transferReq,
    input  wire logic        transferDone,
    // Interrupt
    output logic             irq
);
    import camera_trigger_pkg::*;

    // ==========================================================
    // State record
    typedef struct packed {
        cap_state_e        st;
        logic              awDone;
        logic [4:0]        awAddr;
        logic              wDone;
        logic [31:0]       wData;
        logic [3:0]        wStrb;
        logic              bValid;
        logic [1:0]        bResp;
        logic              rValid;
        logic [1:0]        rResp;
        logic [31:0]       rData;
        logic [CTRL_W-1:0] ctrl;
        logic [15:0]       delayUs;
        logic [15:0]       timeoutMs;
        logic [15:0]       exposeUs;
        logic [15:0]       errCnt;
        logic [IRQ_W-1:0]  irqStat;
        logic [IRQ_W-1:0]  irqMask;
        logic [4:0]        usDiv;
        logic [9:0]        msDiv;
        logic [15:0]       timer;
        logic [15:0]       toCnt;
        logic              trigLevel;
        logic              exposing;
        logic              exposeStart;
        logic              transferReq;
        logic              globalRows;
    } ctl_s;

    ctl_s s;
    ctl_s next_s;

    logic pinLevel;
    logic pinRise;
    logic pinFall;

    // ==========================================================
    // Trigger pin conditioning
    trigger_sync u_sync (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .trigIn    (trigIn),
        .level     (pinLevel),
        .risePulse (pinRise),
        .fallPulse (pinFall)
    );

    // Merge a write into a stored word, lane by lane
    function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction : mergeStrb

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic              awHs;
        logic              wHs;
        logic [4:0]        wAddr;
        logic [31:0]       wVal;
        logic [3:0]        wSt;
        logic [31:0]       m;
        logic              usTick;
        logic              msTick;
        logic              hwMode;
        logic              trig;
        logic              toEvt;
        logic [IRQ_W-1:0]  setIrq;
        logic [IRQ_W-1:0]  clrIrq;
        logic [31:0]       rd;
        logic              rdOk;
        awHs   = s_axi_awvalid & s_axi_awready;
        wHs    = s_axi_wvalid & s_axi_wready;
        wAddr  = awHs ? s_axi_awaddr : s.awAddr;
        wVal   = wHs ? s_axi_wdata : s.wData;
        wSt    = wHs ? s_axi_wstrb : s.wStrb;
        m      = 32'h0;
        rd     = 32'h0;
        rdOk   = 1'b1;
        setIrq = '0;
        clrIrq = '0;
        toEvt  = 1'b0;
        trig   = 1'b0;
        next_s = s;

        next_s.exposeStart = 1'b0;
        next_s.transferReq = 1'b0;

        // Tick dividers; one enable pulse per microsecond and millisecond
        usTick = (s.usDiv == 5'(US_CYCLES - 1));
        msTick = usTick && (s.msDiv == 10'(MS_US - 1));
        next_s.usDiv = usTick ? 5'h00 : s.usDiv + 5'h01;
        if (usTick) begin
            next_s.msDiv = msTick ? 10'h000 : s.msDiv + 10'h001;
        end

        // Pin level is only captured while reporting is enabled
        if (s.ctrl[CTRL_STATUS_EN]) begin
            next_s.trigLevel = pinLevel; // RL6
        end

        // Trigger source selection
        hwMode = (s.ctrl[CTRL_MODE_LSB +: 2] == MODE_FALLING) ||
                 (s.ctrl[CTRL_MODE_LSB +: 2] == MODE_RISING);
        unique case (s.ctrl[CTRL_MODE_LSB +: 2])
            MODE_SOFT:    trig = 1'b1;    // RL3
            MODE_FALLING: trig = pinFall; // RL1
            MODE_RISING:  trig = pinRise; // RL2
            default:      trig = 1'b0;
        endcase

        // Capture sequencer; triggers outside IDLE are dropped
        unique case (s.st)
            ST_IDLE: begin
                if (trig) begin // RL8
                    setIrq[IRQ_CAPTURE] = 1'b1;
                    if (s.ctrl[CTRL_DELAY_EN] && s.delayUs != 16'h0000) begin
                        next_s.st    = ST_DELAY; // RL4
                        next_s.timer = s.delayUs;
                    end else begin
                        next_s.st          = ST_EXPOSE;
                        next_s.timer       = s.exposeUs;
                        next_s.exposing    = 1'b1;
                        next_s.exposeStart = 1'b1;
                        next_s.globalRows  = hwMode && s.ctrl[CTRL_GLOBAL_EN]; // RL7
                    end
                end
            end
            ST_DELAY: begin
                if (usTick) begin
                    next_s.timer = s.timer - 16'h0001;
                    if (s.timer <= 16'h0001) begin
                        next_s.st          = ST_EXPOSE; // RL4
                        next_s.timer       = s.exposeUs;
                        next_s.exposing    = 1'b1;
                        next_s.exposeStart = 1'b1;
                        next_s.globalRows  = hwMode && s.ctrl[CTRL_GLOBAL_EN]; // RL7
                    end
                end
            end
            ST_EXPOSE: begin
                // A zero exposure still lasts until the next microsecond tick
                if (usTick) begin
                    next_s.timer = s.timer - 16'h0001;
                    if (s.timer <= 16'h0001) begin
                        next_s.st          = ST_TRANSFER; // RL8
                        next_s.exposing    = 1'b0;
                        next_s.globalRows  = 1'b0;
                        next_s.transferReq = 1'b1;
                    end
                end
            end
            ST_TRANSFER: begin
                if (transferDone && !s.transferReq) begin
                    next_s.st              = ST_IDLE; // RL8
                    setIrq[IRQ_FRAME]      = 1'b1;
                end
            end
        endcase

        // Trigger timeout; counts only while waiting for a pin trigger
        if (!hwMode || s.timeoutMs == 16'h0000 || s.st != ST_IDLE || trig) begin
            next_s.toCnt = 16'h0000; // RL9
        end else if (msTick) begin
            if (s.toCnt + 16'h0001 >= s.timeoutMs) begin
                toEvt        = 1'b1; // RL5
                next_s.toCnt = 16'h0000;
            end else begin
                next_s.toCnt = s.toCnt + 16'h0001;
            end
        end
        setIrq[IRQ_TIMEOUT] = toEvt;

        // Write channel; address and data may come in either order
        if (awHs) begin
            next_s.awDone = 1'b1;
            next_s.awAddr = s_axi_awaddr;
        end
        if (wHs) begin
            next_s.wDone = 1'b1;
            next_s.wData = s_axi_wdata;
            next_s.wStrb = s_axi_wstrb;
        end
        if ((s.awDone || awHs) && (s.wDone || wHs)) begin
            next_s.awDone = 1'b0;
            next_s.wDone  = 1'b0;
            next_s.bValid = 1'b1;
            next_s.bResp  = RESP_OKAY;
            unique case ({wAddr[4:2], 2'b00})
                OFF_CTRL: begin
                    m           = mergeStrb({27'h0, s.ctrl}, wVal, wSt);
                    next_s.ctrl = m[CTRL_W-1:0];
                end
                OFF_DELAY: begin
                    m              = mergeStrb({16'h0, s.delayUs}, wVal, wSt);
                    next_s.delayUs = m[15:0];
                end
                OFF_TIMEOUT: begin
                    m                = mergeStrb({16'h0, s.timeoutMs}, wVal, wSt);
                    next_s.timeoutMs = m[15:0];
                end
                OFF_EXPOSE: begin
                    m               = mergeStrb({16'h0, s.exposeUs}, wVal, wSt);
                    next_s.exposeUs = m[15:0];
                end
                OFF_IRQMASK: begin
                    m              = mergeStrb({29'h0, s.irqMask}, wVal, wSt);
                    next_s.irqMask = m[IRQ_W-1:0];
                end
                OFF_STATUS, OFF_ERRCNT, OFF_IRQSTAT: begin
                    // Read-only words; the write is accepted and has no effect
                end
                default: next_s.bResp = RESP_SLVERR;
            endcase
        end
        if (s.bValid && s_axi_bready) begin
            next_s.bValid = 1'b0;
        end

        // Read channel; reading the interrupt status clears it
        unique case ({s_axi_araddr[4:2], 2'b00})
            OFF_CTRL:    rd = {27'h0, s.ctrl};
            OFF_DELAY:   rd = {16'h0, s.delayUs};
            OFF_TIMEOUT: rd = {16'h0, s.timeoutMs};
            OFF_EXPOSE:  rd = {16'h0, s.exposeUs};
            OFF_STATUS:  rd = {26'h0, s.st, s.globalRows, s.exposing,
                               s.st != ST_IDLE, s.trigLevel}; // RL6
            OFF_ERRCNT:  rd = {16'h0, s.errCnt};
            OFF_IRQSTAT: rd = {29'h0, s.irqStat};
            OFF_IRQMASK: rd = {29'h0, s.irqMask};
            default:     rdOk = 1'b0;
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rValid = 1'b1;
            next_s.rData  = rd;
            next_s.rResp  = rdOk ? RESP_OKAY : RESP_SLVERR;
            if ({s_axi_araddr[4:2], 2'b00} == OFF_IRQSTAT) begin
                clrIrq = s.irqStat;
            end
        end
        if (s.rValid && s_axi_rready) begin
            next_s.rValid = 1'b0;
        end

        // Error count wraps; a fresh event beats a same-cycle clear
        if (toEvt) begin
            next_s.errCnt = s.errCnt + 16'h0001; // RL5
        end
        next_s.irqStat = (s.irqStat & ~clrIrq) | setIrq;
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s           <= '0;
            s.st        <= ST_IDLE;
            s.ctrl      <= CTRL_RESET;
            s.delayUs   <= DELAY_RESET;
            s.timeoutMs <= TOUT_RESET;
            s.exposeUs  <= EXP_RESET;
            s.irqMask   <= MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready = !s.awDone && !s.bValid;
    assign s_axi_wready  = !s.wDone && !s.bValid;
    assign s_axi_bvalid  = s.bValid;
    assign s_axi_bresp   = s.bResp;
    assign s_axi_arready = !s.rValid;
    assign s_axi_rvalid  = s.rValid;
    assign s_axi_rdata   = s.rData;
    assign s_axi_rresp   = s.rResp;
    assign exposeStart   = s.exposeStart;
    assign exposing      = s.exposing;
    assign globalRows    = s.globalRows;  // RL7
    assign transferReq   = s.transferReq;
    assign irq           = |(s.irqStat & s.irqMask);
endmodule : camera_trigger_control

// file: src/camera_trigger_pkg.sv
// Shared constants for the camera trigger controller
package camera_trigger_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [4:0] OFF_CTRL    = 5'h00;
    localparam logic [4:0] OFF_DELAY   = 5'h04;
    localparam logic [4:0] OFF_TIMEOUT = 5'h08;
    localparam logic [4:0] OFF_EXPOSE  = 5'h0c;
    localparam logic [4:0] OFF_STATUS  = 5'h10;
    localparam logic [4:0] OFF_ERRCNT  = 5'h14;
    localparam logic [4:0] OFF_IRQSTAT = 5'h18;
    localparam logic [4:0] OFF_IRQMASK = 5'h1c;
    // ==========================================================
    // Control fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DELAY_EN  = 2;
    localparam int CTRL_STATUS_EN = 3;
    localparam int CTRL_GLOBAL_EN = 4;
    localparam int CTRL_W         = 5;
    localparam logic [1:0] MODE_SOFT    = 2'h0;
    localparam logic [1:0] MODE_FALLING = 2'h1;
    localparam logic [1:0] MODE_RISING  = 2'h2;
    // ==========================================================
    // Interrupt bits
    localparam int IRQ_W        = 3;
    localparam int IRQ_CAPTURE  = 0;
    localparam int IRQ_TIMEOUT  = 1;
    localparam int IRQ_FRAME    = 2;
    // ==========================================================
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET  = 5'h00;
    localparam logic [15:0]       DELAY_RESET = 16'h0000;
    localparam logic [15:0]       TOUT_RESET  = 16'h0000;
    localparam logic [15:0]       EXP_RESET   = 16'h0064;
    localparam logic [IRQ_W-1:0]  MASK_RESET  = 3'h0;
    // ==========================================================
    // Timing: 40 ns clock, 1 us and 1 ms tick enables
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_US_NS    = 1000;
    localparam int US_CYCLES     = TICK_US_NS / CLK_PERIOD_NS;
    localparam int MS_US         = 1000;
    // ==========================================================
    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Capture sequencer states
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_DELAY    = 2'b01,
        ST_EXPOSE   = 2'b10,
        ST_TRANSFER = 2'b11
    } cap_state_e;
endpackage : camera_trigger_pkg

// file: src/trigger_sync.sv
// Trigger input synchroniser and edge detector
`timescale 1ns/1ps
module trigger_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Raw trigger pin
    input  wire logic trigIn,
    // Clean level and one-cycle edge pulses
    output logic      level,
    output logic      risePulse,
    output logic      fallPulse
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_s;

    sync_s s;
    sync_s next_s;

    // Only the second stage and its delayed copy feed the edge logic
    always_comb begin
        next_s      = s;
        next_s.meta = trigIn;
        next_s.sync = s.meta;
        next_s.prev = s.sync;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level     = s.sync;
    assign risePulse = s.sync & ~s.prev; // RL9
    assign fallPulse = ~s.sync & s.prev; // RL9
endmodule : trigger_sync

// file: testbench/trigger_chk.sv
// Port-level checker for the camera trigger controller
`timescale 1ns/1ps
module trigger_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Sequencing
    input wire logic        exposeStart,
    input wire logic        exposing,
    input wire logic        globalRows,
    input wire logic        transferReq,
    input wire logic        transferDone
);
    import camera_trigger_pkg::*;
    logic pend;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Transfer outstanding; done in the request cycle is ignored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) pend <= 1'b0;
        else if (transferReq) pend <= 1'b1;
        else if (transferDone) pend <= 1'b0;
    end
    // ==========================================================
    // Sequencing
    property p_expose_pulse; exposeStart |-> exposing ##1 !exposeStart; endproperty
    a_expose_pulse: assert property (p_expose_pulse) else $error("start not one pulse");
    property p_xfer_fall; $fell(exposing) |-> transferReq; endproperty
    a_xfer_fall: assert property (p_xfer_fall) else $error("no transfer at exposure end");
    property p_xfer_pulse; transferReq |-> $past(exposing) ##1 !transferReq; endproperty
    a_xfer_pulse: assert property (p_xfer_pulse) else $error("transfer request shape");
    property p_no_new; exposeStart |-> !pend; endproperty
    a_no_new: assert property (p_no_new) else $error("exposure before transfer done");
    property p_global; globalRows |-> exposing; endproperty
    a_global: assert property (p_global) else $error("global rows outside exposure");
    // ==========================================================
    // Register bus
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_b_okay; s_axi_bvalid |-> s_axi_bresp == RESP_OKAY; endproperty
    a_b_okay: assert property (p_b_okay) else $error("write response not okay");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while response pends");
endmodule : trigger_chk

bind camera_trigger_control trigger_chk chk_u (
    .mclk(mclk), .reset_n(reset_n), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .exposeStart(exposeStart), .exposing(exposing),
    .globalRows(globalRows), .transferReq(transferReq), .transferDone(transferDone));

// file: testbench/sensor_xfer_model.sv
// Sensor readout model: answers each transfer request after a short or long wait
`timescale 1ns/1ps
module sensor_xfer_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Handshake with the controller
    input  wire logic transferReq,
    input  wire logic slow,
    output logic      transferDone
);
    int cnt;
    // ==========================================================
    // Slow mode keeps the transfer open long enough to collide with triggers
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            transferDone <= 1'b0;
        end else begin
            transferDone <= (cnt == 1);
            if (transferReq) cnt <= slow ? 60 : 3;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule : sensor_xfer_model

// file: testbench/tb_top.sv
// Self-checking bench for the camera trigger controller
`timescale 1ns/1ps
module tb_top;
    import camera_trigger_pkg::*;
    logic mclk = 0, reset_n = 0, trigIn = 0, slow = 0, transferDone;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, exposeStart, exposing, globalRows, transferReq, irq;
    logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int err_total = 0, samples_checked = 0, nStart = 0, n0, lat;
    bit globalSeen = 0;

    camera_trigger_control dut_u (
        .mclk(mclk), .reset_n(reset_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .trigIn(trigIn), .exposeStart(exposeStart), .exposing(exposing),
        .globalRows(globalRows), .transferReq(transferReq),
        .transferDone(transferDone), .irq(irq));
    sensor_xfer_model part_u (.mclk(mclk), .reset_n(reset_n), .transferReq(transferReq),
        .slow(slow), .transferDone(transferDone));

    initial begin
        forever #20 mclk = ~mclk;
    end
    // Count exposures and note global-start exposures
    always @(posedge mclk) begin
        if (exposeStart === 1'b1) nStart++;
        if (globalRows === 1'b1 && exposing === 1'b1) globalSeen = 1;
    end
    // ==========================================================
    // Bus tasks
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1;
        s_axi_wdata <= d; s_axi_wstrb <= 4'hf; s_axi_bready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask : wr
    // Read accepts data one cycle late so the hold rule is exercised
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        s_axi_arvalid <= 1; s_axi_araddr <= a;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        chk("rresp", {30'h0, s_axi_rresp}, 32'h0);
        s_axi_rready <= 0;
    endtask : rd
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic pin(input logic v);
        @(posedge mclk);
        trigIn <= v;
        repeat (6) @(posedge mclk);
    endtask : pin
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // ==========================================================
    // Watchdog
    initial begin
        repeat (80000) @(posedge mclk);
        err_total++;
        final_report;
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1;
        rd(OFF_CTRL, rv); chk("ctrl reset", rv, 32'h0);
        rd(OFF_EXPOSE, rv); chk("expose reset", rv, 32'h64);
        wr(OFF_EXPOSE, 32'h2);
        chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
        // Software mode runs frames back to back with the pin idle
        repeat (3000) @(posedge mclk);
        n0 = nStart;
        repeat (600) @(posedge mclk);
        chk("soft frames", 32'(nStart - n0 >= 2), 32'h1);
        wr(OFF_CTRL, {27'h0, 5'h08 | 5'(MODE_FALLING)});
        repeat (300) @(posedge mclk);
        n0 = nStart;
        pin(1); repeat (200) @(posedge mclk);
        chk("falling ignores rise", 32'(nStart - n0), 32'h0);
        rd(OFF_STATUS, rv); chk("pin level high", rv & 32'h1, 32'h1);
        pin(0); repeat (200) @(posedge mclk);
        chk("falling capture", 32'(nStart - n0), 32'h1);
        rd(OFF_STATUS, rv); chk("pin level low", rv & 32'h1, 32'h0);
        // Rising mode with global start
        wr(OFF_CTRL, {27'h0, 5'h18 | 5'(MODE_RISING)});
        pin(1); pin(0);
        repeat (200) @(posedge mclk);
        n0 = nStart;
        pin(1); repeat (200) @(posedge mclk);
        chk("rising capture", 32'(nStart - n0), 32'h1);
        chk("global rows", 32'(globalSeen), 32'h1);
        // Triggers during exposure and transfer are not taken
        wr(OFF_EXPOSE, 32'h14);
        slow <= 1;
        pin(0);
        n0 = nStart;
        pin(1); pin(0); pin(1); pin(0); pin(1);
        // A further rising edge lands inside the slow transfer
        while (transferReq !== 1'b1) @(posedge mclk);
        pin(0); pin(1);
        repeat (800) @(posedge mclk);
        chk("one per sequence", 32'(nStart - n0), 32'h1);
        slow <= 0;
        // Delay of 4 us from pin edge to exposure
        wr(OFF_EXPOSE, 32'h2);
        wr(OFF_DELAY, 32'h4);
        wr(OFF_CTRL, {27'h0, 5'h04 | 5'(MODE_RISING)});
        pin(0);
        lat = 0;
        @(posedge mclk);
        trigIn <= 1;
        do begin
            @(posedge mclk);
            lat++;
        end while (exposeStart !== 1'b1 && lat < 2000);
        chk("delay window", 32'(lat >= 70 && lat <= 110), 32'h1);
        // Timeout of 1 ms in falling mode with its interrupt unmasked
        wr(OFF_IRQMASK, 32'h2);
        rd(OFF_IRQSTAT, rv);
        wr(OFF_TIMEOUT, 32'h1);
        wr(OFF_CTRL, {27'h0, 5'(MODE_FALLING)});
        lat = 0;
        while (irq !== 1'b1 && lat < 30000) begin
            @(posedge mclk);
            lat++;
        end
        chk("timeout irq", {31'h0, irq}, 32'h1);
        wr(OFF_ERRCNT, 32'h55);
        rd(OFF_ERRCNT, rv); chk("error count", rv, 32'h1);
        rd(OFF_IRQSTAT, rv); chk("timeout flag", rv & 32'h2, 32'h2);
        rd(OFF_IRQSTAT, rv); chk("flag cleared", rv & 32'h2, 32'h0);
        chk("irq released", {31'h0, irq}, 32'h0);
        final_report;
    end
endmodule : tb_top
